// File: sts_flag_bank.sv
/*
  Bank of sticky flags. A set term always wins over a clear, and a hold
  term (condition still present) blocks the clear.
  Assumes clear requests are one-cycle pulses from the software port.
*/
`timescale 1ns/100ps
`default_nettype none
module sts_flag_bank
  import sts_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic arst_n,
  sts_flag_if.bank  fl
);

  logic [NFLAGS-1:0] flag_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= '0;
    end else begin
      flag_q <= fl.set | (flag_q & ~(fl.clr & ~fl.hold));
    end
  end

  assign fl.q = flag_q;

endmodule : sts_flag_bank
`default_nettype wire

// File: sts_flag_if.sv
/*
  Interface carrying set, hold and clear terms of the sticky flags
  between the supervisor top and its flag bank.
  Assumes both ends share the core clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface sts_flag_if;
  import sts_pkg::*;
  logic [NFLAGS-1:0] set;
  logic [NFLAGS-1:0] hold;
  logic [NFLAGS-1:0] clr;
  logic [NFLAGS-1:0] q;
  modport bank (input set, input hold, input clr, output q);
  modport ctrl (output set, output hold, output clr, input q);
endinterface : sts_flag_if
`default_nettype wire

// File: sts_mcu_model.sv
/*
  Microcontroller stand-in that writes flag clears to the supervisor.
  Assumes requests are raised by the bench for one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sts_mcu_model
  import sts_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic              req,
  input  wire logic [NFLAGS-1:0] mask,
  output logic      [NFLAGS-1:0] flag_clr
);
  // A clear write lasts one clock, as the software port delivers it.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) flag_clr <= '0;
    else flag_clr <= req ? mask : '0;
  end
endmodule : sts_mcu_model
`default_nettype wire

// File: sts_pkg.sv
/*
  Package of the supply and thermal supervisor: modes, timing constants
  and the layout of the clear-request vector.
  Assumes a single 20 MHz core clock.
*/
package sts_pkg;

  localparam int unsigned CLK_HZ = 20000000;

  // Short-circuit filter time, shortest legal value used (1.6 ms).
  localparam int unsigned SC_FILTER_US  = 1600;
  localparam int unsigned SC_FILTER_CYC =
    (SC_FILTER_US * (CLK_HZ / 1000000));

  localparam int unsigned RST_DELAY_MS_DEF  = 10;
  localparam int unsigned RST_DELAY_CYC_DEF =
    RST_DELAY_MS_DEF * (CLK_HZ / 1000);
  localparam int unsigned TSD_WAIT_MS_DEF   = 1000;
  localparam int unsigned TSD_WAIT_CYC_DEF  =
    TSD_WAIT_MS_DEF * (CLK_HZ / 1000);

  localparam int unsigned CNT_W          = 32;
  localparam int unsigned TSD_EXT_FACTOR = 64;
  localparam logic [4:0]  TSD_EVT_LIMIT  = 5'h10;
  localparam logic [1:0]  CAN_FAIL_NONE  = 2'h0;
  localparam logic [1:0]  CAN_FAIL_TSD   = 2'h1;

  // Index of each flag in the flag and clear vectors.
  localparam int unsigned F_BAT_UV   = 0;
  localparam int unsigned F_BAT_OV   = 1;
  localparam int unsigned F_MAIN_PW  = 2;
  localparam int unsigned F_MAIN_UV  = 3;
  localparam int unsigned F_MAIN_OV  = 4;
  localparam int unsigned F_MAIN_SC  = 5;
  localparam int unsigned F_FAILURE  = 6;
  localparam int unsigned F_AUX_UV   = 7;
  localparam int unsigned F_CAN_UV   = 8;
  localparam int unsigned F_BLK_TSD  = 9;
  localparam int unsigned F_AUX_OT   = 10;
  localparam int unsigned F_TPW      = 11;
  localparam int unsigned F_CHIP_TSD = 12;
  localparam int unsigned F_TSD_SAFE = 13;
  localparam int unsigned NFLAGS     = 14;

  typedef enum logic [2:0] {
    STS_INIT, STS_NORMAL, STS_STOP, STS_SLEEP, STS_RESTART, STS_FAILSAFE
  } sts_mode_e;

endpackage : sts_pkg

// File: sts_supervisor.sv
/*
  Supply and thermal supervisor: sticky diagnostic flags, reset and fail
  outputs, forced Restart and Fail-Safe entry, thermal shutdown recovery.
  Assumes comparator inputs arrive asynchronously from analog blocks and
  that software requests (mode, clears) are already on core_clk.
*/
// Overview of operation
// - Battery undervoltage sets its flag in Init, Restart, Normal; clear after end.
// - Battery undervoltage disables short protection; thermal protection stays on.
// - Stop mode skips battery monitoring unless peak current or prewarning.
// - Battery overvoltage flag in active modes or with charge pump on.
// - With charge pump off, overvoltage flag stays until software clears it.
// - Main regulator prewarning flag when output below first threshold.
// - Main output below reset threshold pulls reset, enters Restart, flag later.
// - Increased hysteresis releases reset only at highest rising threshold.
// - Sleep mode never sets main prewarning or undervoltage flags.
// - Main overvoltage sets flag; with reset enable and config 1, Restart.
// - Overvoltage Restart returns to Normal and clears reset enable.
// - Overvoltage with reset enable and config 0 enters Fail-Safe.
// - Short detection only above battery threshold, after filter time.
// - Short sets flags, turns regulator off, fail output, Fail-Safe.
// - Short Fail-Safe leaves on CAN, wake input or GPIO wake.
// - Aux undervoltage sticky flag, blanked at power-up and switching.
// - Transceiver supply undervoltage sticky flag with CAN enabled.
// - Block overheat switches it off, sets shutdown and aux flags.
// - CAN overheat disables transmitter, fail field 01, auto recovery.
// - Temperature prewarning flag; clearable only once condition ended.
// - Chip shutdown enters Fail-Safe, waits after cooling, Restart, Normal.
// - Extension bit counts shutdowns; at 16 safe flag and 64x wait.
// - Short-circuit filter time is nominally 2 ms; the code uses 1.6 ms (SC_FILTER_US).
`timescale 1ns/100ps
`default_nettype none
module sts_supervisor
  import sts_pkg::*;
#(
  parameter int unsigned RST_DELAY_CYC = RST_DELAY_CYC_DEF,
  parameter int unsigned TSD_WAIT_CYC  = TSD_WAIT_CYC_DEF
) (
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic              battery_uv_cmp,
  input  wire logic              battery_ov_cmp,
  input  wire logic              peak_current_cmp,
  input  wire logic              main_pw_cmp,
  input  wire logic              main_rst_fall_cmp,
  input  wire logic              main_rst_rise_cmp,
  input  wire logic              main_rst_high_cmp,
  input  wire logic              main_ov_cmp,
  input  wire logic              aux_uv_cmp,
  input  wire logic              can_uv_cmp,
  input  wire logic              aux_ot_cmp,
  input  wire logic              can_ot_cmp,
  input  wire logic              tpw_cmp,
  input  wire logic              chip_tsd_cmp,
  input  wire logic              wake_event,
  input  wire logic              stop_req,
  input  wire logic              sleep_req,
  input  wire logic              init_done,
  input  wire logic              charge_pump_en,
  input  wire logic              rst_hys_inc,
  input  wire logic              config_state_bit,
  input  wire logic              ov_rst_enable_set,
  input  wire logic              aux_enable_set,
  input  wire logic              aux_switching,
  input  wire logic              aux_blank,
  input  wire logic              can_enable,
  input  wire logic              shutdown_delay_extend,
  input  wire logic [NFLAGS-1:0] flag_clr,
  output logic [NFLAGS-1:0]      flags,
  output logic                   reset_n_out,
  output logic                   fail_output,
  output logic                   main_regulator_on,
  output logic                   main_short_prot_on,
  output logic                   overvolt_reset_enable,
  output logic [1:0]             aux_enable_bits,
  output logic                   can_tx_enable,
  output logic [1:0]             can_fail,
  output logic [4:0]             tsd_event_count,
  output sts_mode_e              mode
);

  localparam int unsigned NSYNC = 14;
  localparam logic [CNT_W-1:0] SC_LOAD  = CNT_W'(SC_FILTER_CYC);
  localparam logic [CNT_W-1:0] RD_LOAD  = CNT_W'(RST_DELAY_CYC);
  localparam logic [CNT_W-1:0] TW_LOAD  = CNT_W'(TSD_WAIT_CYC);
  localparam logic [CNT_W-1:0] TWX_LOAD =
    CNT_W'(TSD_WAIT_CYC * TSD_EXT_FACTOR);

  // Three-stage synchronisers; a change counts once stage 2 and 3 agree.
  logic [NSYNC-1:0] s1_q, s2_q, s3_q, c_q;
  logic [NSYNC-1:0] raw;
  assign raw = {battery_uv_cmp, battery_ov_cmp, peak_current_cmp,
                main_pw_cmp, main_rst_fall_cmp, main_rst_rise_cmp,
                main_rst_high_cmp, main_ov_cmp, aux_uv_cmp, can_uv_cmp,
                aux_ot_cmp, can_ot_cmp, tpw_cmp, chip_tsd_cmp};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      c_q  <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      c_q  <= (s2_q & s3_q) | (c_q & (s2_q | s3_q));
    end
  end

  logic bat_uv, bat_ov, peak, m_pw, m_fall, m_rise, m_high, m_ov;
  logic a_uv, k_uv, a_ot, k_ot, t_pw, t_sd;
  assign {bat_uv, bat_ov, peak, m_pw, m_fall, m_rise, m_high, m_ov,
          a_uv, k_uv, a_ot, k_ot, t_pw, t_sd} = c_q;

  sts_flag_if fl ();

  sts_flag_bank u_bank (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .fl       (fl)
  );

  sts_mode_e mode_q;
  logic      rst_low_q, fail_q, reg_on_q, ov_rst_q, ov_restart_q;
  logic      sc_fs_q, tsd_fs_q, cooling_q, tsd_restart_q;
  logic      under_q;
  logic [1:0] aux_en_q;
  logic [4:0] tsd_cnt_q;
  logic       t_sd_d1_q, m_ov_d1_q;

  logic act_mode, stop_mode, bat_mon, bat_ov_mon;
  logic tsd_edge, ov_edge, main_under, released, sc_hit;
  logic rd_done, tw_done, rd_load, tw_load;

  assign act_mode  = (mode_q == STS_INIT) || (mode_q == STS_RESTART) ||
                     (mode_q == STS_NORMAL);
  assign stop_mode = (mode_q == STS_STOP);
  assign bat_mon    = act_mode || (stop_mode && (peak || m_pw));
  assign bat_ov_mon = bat_mon || charge_pump_en;
  assign tsd_edge   = t_sd && !t_sd_d1_q;
  assign ov_edge    = m_ov && !m_ov_d1_q && reg_on_q;

  assign released   = rst_hys_inc ? m_high : m_rise;
  assign main_under = reg_on_q && (m_fall || (under_q && !released));

  assign main_short_prot_on = reg_on_q && !bat_uv;

  sts_timer u_sc_tmr (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run      (main_short_prot_on && main_under),
    .load     (main_short_prot_on && main_under && !under_q),
    .load_val (SC_LOAD),
    .done     (sc_hit)
  );

  assign rd_load = (mode_q != STS_RESTART) || main_under;
  sts_timer u_rd_tmr (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run      (mode_q == STS_RESTART && !main_under),
    .load     (rd_load),
    .load_val (RD_LOAD),
    .done     (rd_done)
  );

  assign tw_load = tsd_fs_q && !t_sd && !cooling_q;
  sts_timer u_tw_tmr (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run      (cooling_q && !t_sd),
    .load     (tw_load),
    .load_val (fl.q[F_TSD_SAFE] ? TWX_LOAD : TW_LOAD),
    .done     (tw_done)
  );

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      t_sd_d1_q <= 1'b0;
      m_ov_d1_q <= 1'b0;
      under_q   <= 1'b0;
    end else begin
      t_sd_d1_q <= t_sd;
      m_ov_d1_q <= m_ov;
      under_q   <= main_under;
    end
  end

  // Mode control; thermal and short events take priority over the rest.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q        <= STS_INIT;
      rst_low_q     <= 1'b1;
      fail_q        <= 1'b0;
      reg_on_q      <= 1'b1;
      ov_restart_q  <= 1'b0;
      sc_fs_q       <= 1'b0;
      tsd_fs_q      <= 1'b0;
      cooling_q     <= 1'b0;
      tsd_restart_q <= 1'b0;
    end else if (tsd_edge) begin
      mode_q    <= STS_FAILSAFE;
      tsd_fs_q  <= 1'b1;
      cooling_q <= 1'b0;
      rst_low_q <= 1'b1;
      reg_on_q  <= 1'b0;
    end else if (sc_hit) begin
      mode_q    <= STS_FAILSAFE;
      reg_on_q  <= 1'b0;
      fail_q    <= 1'b1;
      sc_fs_q   <= 1'b1;
      rst_low_q <= 1'b1;
    end else if (ov_edge && ov_rst_q) begin
      fail_q    <= 1'b1;
      rst_low_q <= 1'b1;
      if (config_state_bit) begin
        mode_q       <= STS_RESTART;
        ov_restart_q <= 1'b1;
      end else begin
        mode_q <= STS_FAILSAFE;
      end
    end else begin
      unique case (mode_q)
        STS_INIT, STS_NORMAL, STS_STOP: begin
          if (main_under) begin
            mode_q    <= STS_RESTART;
            rst_low_q <= 1'b1;
          end else if (mode_q == STS_INIT) begin
            if (init_done) begin
              mode_q <= STS_NORMAL;
            end
          end else if (sleep_req) begin
            mode_q   <= STS_SLEEP;
            reg_on_q <= 1'b0;
          end else if (stop_req) begin
            mode_q <= STS_STOP;
          end
          if (mode_q == STS_INIT && !main_under) begin
            rst_low_q <= 1'b0;
          end
        end
        STS_SLEEP: begin
          if (wake_event) begin
            mode_q    <= STS_RESTART;
            reg_on_q  <= 1'b1;
            rst_low_q <= 1'b1;
          end
        end
        STS_RESTART: begin
          if (rd_done) begin
            mode_q        <= STS_NORMAL;
            rst_low_q     <= 1'b0;
            ov_restart_q  <= 1'b0;
            tsd_restart_q <= 1'b0;
          end
        end
        STS_FAILSAFE: begin
          if (tw_load) begin
            cooling_q <= 1'b1;
          end
          if (tsd_fs_q && tw_done) begin
            mode_q        <= STS_RESTART;
            tsd_fs_q      <= 1'b0;
            cooling_q     <= 1'b0;
            tsd_restart_q <= 1'b1;
            reg_on_q      <= 1'b1;
          end else if (!tsd_fs_q && wake_event) begin
            mode_q   <= STS_RESTART;
            sc_fs_q  <= 1'b0;
            reg_on_q <= 1'b1;
            fail_q   <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ov_rst_q <= 1'b0;
    end else if (ov_restart_q && rd_done) begin
      ov_rst_q <= 1'b0;
    end else if (ov_rst_enable_set) begin
      ov_rst_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aux_en_q <= 2'h0;
    end else if (a_ot && aux_en_q != 2'h0) begin
      aux_en_q <= 2'h0;
    end else if (aux_enable_set) begin
      aux_en_q <= 2'h3;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tsd_cnt_q <= 5'h0;
    end else if (!shutdown_delay_extend ||
                 (fl.clr[F_CHIP_TSD] && !fl.hold[F_CHIP_TSD])) begin
      tsd_cnt_q <= 5'h0;
    end else if (tsd_edge && tsd_cnt_q != TSD_EVT_LIMIT) begin
      tsd_cnt_q <= tsd_cnt_q + 5'h1;
    end
  end

  logic rel_edge;
  assign rel_edge = (mode_q == STS_RESTART) && rd_done && under_q == 1'b0
                    && !ov_restart_q && !tsd_restart_q;

  always_comb begin
    fl.set = '0;
    fl.hold = '0;
    fl.set[F_BAT_UV]   = bat_mon && bat_uv;
    fl.set[F_BAT_OV]   = bat_ov_mon && bat_ov;
    fl.set[F_MAIN_PW]  = reg_on_q && m_pw && mode_q != STS_SLEEP;
    fl.set[F_MAIN_UV]  = rel_edge && reg_on_q;
    fl.set[F_MAIN_OV]  = ov_edge;
    fl.set[F_MAIN_SC]  = sc_hit && !tsd_edge;
    fl.set[F_FAILURE]  = sc_hit && !tsd_edge;
    fl.set[F_AUX_UV]   = aux_en_q != 2'h0 && a_uv && !aux_blank &&
                         !aux_switching;
    fl.set[F_CAN_UV]   = can_enable && k_uv;
    fl.set[F_BLK_TSD]  = (a_ot && aux_en_q != 2'h0) || (k_ot && can_enable);
    fl.set[F_AUX_OT]   = a_ot && aux_en_q != 2'h0;
    fl.set[F_TPW]      = t_pw;
    fl.set[F_CHIP_TSD] = tsd_edge;
    fl.set[F_TSD_SAFE] = shutdown_delay_extend && tsd_edge &&
                         tsd_cnt_q == TSD_EVT_LIMIT - 5'h1;
    fl.hold[F_BAT_UV]   = bat_uv;
    fl.hold[F_BAT_OV]   = bat_ov && bat_ov_mon;
    fl.hold[F_BLK_TSD]  = a_ot || k_ot;
    fl.hold[F_TPW]      = t_pw;
    fl.hold[F_CHIP_TSD] = t_sd || mode_q != STS_NORMAL;
  end

  assign fl.clr = flag_clr;

  assign can_tx_enable = can_enable && !k_ot;
  assign can_fail      = (can_enable && k_ot) ? CAN_FAIL_TSD : CAN_FAIL_NONE;

  assign flags                 = fl.q;
  assign reset_n_out           = !rst_low_q;
  assign fail_output           = fail_q;
  assign main_regulator_on     = reg_on_q;
  assign overvolt_reset_enable = ov_rst_q;
  assign aux_enable_bits       = aux_en_q;
  assign tsd_event_count       = tsd_cnt_q;
  assign mode                  = mode_q;

endmodule : sts_supervisor
`default_nettype wire

// File: sts_supervisor_props.sv
/*
  Concurrent checks on the ports of the supply and thermal supervisor.
  Assumes it is bound to the top module and shares its core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sts_supervisor_props
  import sts_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              arst_n,
  input wire logic              battery_uv_cmp,
  input wire logic              main_rst_fall_cmp,
  input wire logic              main_rst_high_cmp,
  input wire logic              main_ov_cmp,
  input wire logic              aux_ot_cmp,
  input wire logic              can_ot_cmp,
  input wire logic              chip_tsd_cmp,
  input wire logic              rst_hys_inc,
  input wire logic              config_state_bit,
  input wire logic              can_enable,
  input wire logic [NFLAGS-1:0] flag_clr,
  input wire logic [NFLAGS-1:0] flags,
  input wire logic              reset_n_out,
  input wire logic              fail_output,
  input wire logic              main_regulator_on,
  input wire logic              main_short_prot_on,
  input wire logic              overvolt_reset_enable,
  input wire logic [1:0]        aux_enable_bits,
  input wire logic              can_tx_enable,
  input wire logic [1:0]        can_fail,
  input wire logic [4:0]        tsd_event_count,
  input wire sts_mode_e         mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  bat_uv_flag_a: assert property (
    (battery_uv_cmp && mode == STS_NORMAL)[*8] |-> flags[F_BAT_UV])
    else $error("battery undervoltage flag missing");
  short_prot_a: assert property (
    battery_uv_cmp[*6] |-> !main_short_prot_on)
    else $error("short protection active in undervoltage");
  uv_reset_a: assert property (
    (main_rst_fall_cmp && main_regulator_on)[*7] |-> !reset_n_out)
    else $error("reset not pulled on main undervoltage");
  hys_release_a: assert property (
    (rst_hys_inc && !main_rst_high_cmp)[*6] |-> !$rose(reset_n_out))
    else $error("reset released below highest threshold");
  main_ov_flag_a: assert property (
    (main_ov_cmp && main_regulator_on)[*7] |-> flags[F_MAIN_OV])
    else $error("main overvoltage flag missing");
  ov_restart_a: assert property (
    $rose(main_ov_cmp) && overvolt_reset_enable && config_state_bit &&
    mode == STS_NORMAL |->
    ##[3:7] (mode == STS_RESTART && fail_output && !reset_n_out))
    else $error("overvoltage restart missing");
  ov_failsafe_a: assert property (
    $rose(main_ov_cmp) && overvolt_reset_enable && !config_state_bit &&
    mode == STS_NORMAL |-> ##[3:7] (mode == STS_FAILSAFE && fail_output))
    else $error("overvoltage fail-safe missing");
  aux_ot_off_a: assert property (
    $rose(aux_ot_cmp) && aux_enable_bits != 2'h0 |-> ##[2:7]
    (aux_enable_bits == 2'h0 && flags[F_AUX_OT] && flags[F_BLK_TSD]))
    else $error("aux regulator not shut down");
  can_ot_off_a: assert property (
    (can_enable && can_ot_cmp)[*6] |->
    (!can_tx_enable && can_fail == CAN_FAIL_TSD))
    else $error("transmitter not disabled on overheat");
  chip_tsd_a: assert property (
    $rose(chip_tsd_cmp) |-> ##[3:7]
    (mode == STS_FAILSAFE && flags[F_CHIP_TSD]))
    else $error("thermal shutdown not entered");
  tsd_safe_a: assert property (
    $rose(tsd_event_count == 5'h10) |-> ##[0:1] flags[F_TSD_SAFE])
    else $error("safe flag missing at event limit");
  count_cap_a: assert property (
    tsd_event_count <= 5'h10)
    else $error("event counter above limit");
  clr_refused_a: assert property (
    (battery_uv_cmp && mode == STS_NORMAL)[*8] ##0 flag_clr[F_BAT_UV]
    |=> flags[F_BAT_UV])
    else $error("flag cleared while condition present");
endmodule : sts_supervisor_props
`default_nettype wire

// File: sts_supervisor_tb.sv
/*
  Self-checking bench of the supply and thermal supervisor.
  Assumes short reset and wait counts given through the parameters.
*/
`timescale 1ns/100ps
`default_nettype none
module sts_supervisor_tb
  import sts_pkg::*;
;
  localparam int RD = 20;
  localparam int TW = 10;
  logic core_clk = 1'b0;
  logic arst_n   = 1'b0;
  logic battery_uv_cmp, battery_ov_cmp, peak_current_cmp, main_pw_cmp;
  logic main_rst_fall_cmp, main_rst_rise_cmp, main_rst_high_cmp;
  logic main_ov_cmp, aux_uv_cmp, can_uv_cmp, aux_ot_cmp, can_ot_cmp;
  logic tpw_cmp, chip_tsd_cmp, wake_event, stop_req, sleep_req, init_done;
  logic charge_pump_en, rst_hys_inc, config_state_bit, ov_rst_enable_set;
  logic aux_enable_set, aux_switching, aux_blank, can_enable, clr_req;
  logic shutdown_delay_extend, reset_n_out, fail_output, main_regulator_on;
  logic main_short_prot_on, overvolt_reset_enable, can_tx_enable;
  logic [NFLAGS-1:0] flag_clr, flags, exp_f, clr_mask;
  logic [1:0]        aux_enable_bits, can_fail;
  logic [4:0]        tsd_event_count;
  logic [31:0]       seed = 32'h0001735E;
  sts_mode_e         mode;
  int miscompares = 0, total_checks = 0, cycles = 0, n;

  always #25 core_clk = ~core_clk;

  sts_supervisor #(.RST_DELAY_CYC(RD), .TSD_WAIT_CYC(TW)) DUT (.*);
  sts_mcu_model u_mcu (.core_clk(core_clk), .arst_n(arst_n), .req(clr_req),
                       .mask(clr_mask), .flag_clr(flag_clr));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic err(input string s);
    miscompares++;
    $display("[ERR] %0t %s", $time, s);
  endtask
  task automatic chk(input logic ok, input string s);
    total_checks++;
    if (ok !== 1'b1) err(s);
  endtask
  task automatic wait_mode(input sts_mode_e m, input int lim, output int t);
    t = 0;
    while (mode !== m && t < lim) begin
      step(1);
      t++;
    end
    chk(mode === m, "mode");
  endtask
  task automatic clear(input logic [NFLAGS-1:0] m);
    clr_mask = m;
    clr_req = 1'b1;
    step(1);
    clr_req = 1'b0;
    step(2);
  endtask
  task automatic tidy;
    step(8);
    clear('1);
    exp_f = '0;
    chk(flags === exp_f, "tidy");
  endtask
  task automatic bring_up;
    arst_n = 1'b0;
    step(10);
    chk(flags === '0 && mode === STS_INIT && reset_n_out === 1'b0, "reset");
    arst_n = 1'b1;
    wait_mode(STS_NORMAL, RD + 50, n);
    chk(reset_n_out === 1'b1, "reset held");
    tidy();
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // The ceiling leaves room above the short-circuit filter wait.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err("timeout");
      wrap_up();
    end
  end

  initial begin
    {battery_uv_cmp, battery_ov_cmp, peak_current_cmp, main_pw_cmp} = '0;
    {main_rst_fall_cmp, main_ov_cmp, aux_uv_cmp, can_uv_cmp} = '0;
    {aux_ot_cmp, can_ot_cmp, tpw_cmp, chip_tsd_cmp, wake_event} = '0;
    {stop_req, sleep_req, charge_pump_en, rst_hys_inc} = '0;
    {config_state_bit, ov_rst_enable_set, aux_enable_set} = '0;
    {aux_switching, aux_blank, can_enable, shutdown_delay_extend} = '0;
    {main_rst_rise_cmp, main_rst_high_cmp, init_done} = 3'h7;
    {clr_req, clr_mask} = '0;
    bring_up();
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      charge_pump_en = seed[0];
      {battery_ov_cmp, battery_uv_cmp} = 2'h1 << i;
      step(8);
      exp_f[i] = 1'b1;
      chk(flags === exp_f, "bat flag");
      chk(main_short_prot_on === (i == 1), "prot");
      clear(exp_f);
      chk(flags === exp_f, "refused");
      {battery_ov_cmp, battery_uv_cmp} = 2'h0;
      step(8);
      chk(main_short_prot_on === 1'b1, "prot back");
      tidy();
    end
    for (int c = 1; c >= 0; c--) begin
      config_state_bit = c[0];
      ov_rst_enable_set = 1'b1;
      step(1);
      ov_rst_enable_set = 1'b0;
      main_ov_cmp = 1'b1;
      wait_mode((c == 1) ? STS_RESTART : STS_FAILSAFE, 10, n);
      chk(flags[F_MAIN_OV] === 1'b1 && fail_output === 1'b1, "ov entry");
      if (c == 1) begin
        wait_mode(STS_NORMAL, RD + 10, n);
        chk(n >= RD - 2 && overvolt_reset_enable === 1'b0, "ov exit");
      end else begin
        main_ov_cmp = 1'b0;
        step(6);
        wake_event = 1'b1;
        step(1);
        wake_event = 1'b0;
        wait_mode(STS_NORMAL, RD + 30, n);
        chk(fail_output === 1'b0, "fail kept");
      end
      main_ov_cmp = 1'b0;
      tidy();
    end
    rst_hys_inc = 1'b1;
    main_pw_cmp = 1'b1;
    {main_rst_fall_cmp, main_rst_rise_cmp, main_rst_high_cmp} = 3'h4;
    wait_mode(STS_RESTART, 10, n);
    chk(reset_n_out === 1'b0 && flags[F_MAIN_PW] === 1'b1, "uv reset");
    {main_rst_fall_cmp, main_rst_rise_cmp} = 2'h1;
    step(RD + 20);
    chk(reset_n_out === 1'b0, "early");
    main_rst_high_cmp = 1'b1;
    main_pw_cmp = 1'b0;
    wait_mode(STS_NORMAL, RD + 20, n);
    chk(reset_n_out === 1'b1 && flags[F_MAIN_UV] === 1'b1, "uv flag");
    rst_hys_inc = 1'b0;
    tidy();
    aux_enable_set = 1'b1;
    step(1);
    {aux_enable_set, can_enable, aux_blank, aux_uv_cmp, can_uv_cmp} = 5'h0F;
    step(8);
    chk(flags[F_AUX_UV] === 1'b0 && flags[F_CAN_UV] === 1'b1, "aux blank");
    {aux_blank, aux_uv_cmp, can_uv_cmp} = 3'h2;
    step(8);
    chk(flags[F_AUX_UV] === 1'b1 && aux_enable_bits !== 2'h0, "aux uv");
    {aux_uv_cmp, aux_ot_cmp, can_ot_cmp} = 3'h3;
    step(8);
    chk(aux_enable_bits === 2'h0 && flags[F_AUX_OT] === 1'b1, "aux off");
    chk(can_tx_enable === 1'b0 && can_fail === CAN_FAIL_TSD, "can off");
    clear('1);
    chk(flags[F_BLK_TSD] === 1'b1 && flags[F_CAN_UV] === 1'b0, "sticky");
    {aux_ot_cmp, can_ot_cmp} = 2'h0;
    step(8);
    chk(can_tx_enable === 1'b1 && aux_enable_bits === 2'h0, "recover");
    can_enable = 1'b0;
    tidy();
    tpw_cmp = 1'b1;
    step(8);
    clear('1);
    chk(flags[F_TPW] === 1'b1, "tpw");
    tpw_cmp = 1'b0;
    shutdown_delay_extend = 1'b1;
    for (int e = 1; e <= 16; e++) begin
      chip_tsd_cmp = 1'b1;
      wait_mode(STS_FAILSAFE, 10, n);
      chip_tsd_cmp = 1'b0;
      wait_mode(STS_NORMAL, 64 * TW + RD + 30, n);
      chk(n >= ((e == 16) ? 64 * TW : TW) && tsd_event_count === e[4:0], "tsd");
    end
    chk(flags[F_TSD_SAFE] === 1'b1 && flags[F_CHIP_TSD] === 1'b1, "safe");
    tidy();
    chk(tsd_event_count === 5'h00, "count");
    shutdown_delay_extend = 1'b0;
    {main_rst_fall_cmp, main_rst_rise_cmp} = 2'h2;
    n = 0;
    while (mode !== STS_FAILSAFE && n < 48000) begin
      step(1);
      n++;
    end
    chk(n >= SC_FILTER_CYC && n < 48000, "filter");
    chk(flags[F_MAIN_SC] === 1'b1 && flags[F_FAILURE] === 1'b1, "short");
    chk(main_regulator_on === 1'b0 && fail_output === 1'b1, "short off");
    {main_rst_fall_cmp, main_rst_rise_cmp, wake_event} = 3'h3;
    step(1);
    wake_event = 1'b0;
    wait_mode(STS_NORMAL, RD + 40, n);
    chk(main_regulator_on === 1'b1, "reg back");
    {stop_req, battery_uv_cmp} = 2'h3;
    step(8);
    chk(mode === STS_STOP && flags[F_BAT_UV] === 1'b0, "stop");
    {stop_req, battery_uv_cmp} = 2'h0;
    bring_up();
    wrap_up();
  end
endmodule : sts_supervisor_tb
`default_nettype wire

bind sts_supervisor sts_supervisor_props u_props (.*);

// File: sts_timer.sv
/*
  Down counter used for filter and wait times. Loading restarts it; done
  pulses one cycle as the count reaches zero.
  Assumes the load value is at least one.
*/
`timescale 1ns/100ps
`default_nettype none
module sts_timer
  import sts_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             run,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_q;
  logic             act_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      act_q <= 1'b0;
    end else if (load) begin
      cnt_q <= load_val;
      act_q <= 1'b1;
    end else if (!run) begin
      act_q <= 1'b0;
    end else if (act_q && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = act_q && run && (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule : sts_timer
`default_nettype wire
